// ===== include/dmsr_pkg.sv
// package: address map, field layout and carrier types of the data memory system register bank
package dmsr_pkg;

    // ****************************************
    // memory map
    // ****************************************
    localparam int unsigned DMSR_GEN_DEPTH = 128;
    localparam int unsigned DMSR_LCD_DEPTH = 32;
    localparam logic [7:0]  DMSR_GEN_LAST  = 8'h7f;
    localparam logic [7:0]  DMSR_LCD_LAST  = 8'h1f;
    localparam logic [3:0]  DMSR_BANK_ZERO = 4'h0;
    localparam logic [3:0]  DMSR_BANK_LCD  = 4'hf;

    // ****************************************
    // system register offsets
    // ****************************************
    localparam logic [7:0] IND1_LOW_OFS   = 8'h80;
    localparam logic [7:0] IND1_HIGH_OFS  = 8'h81;
    localparam logic [7:0] LOOKUP_BUF_OFS = 8'h82;
    localparam logic [7:0] IND2_LOW_OFS   = 8'h83;
    localparam logic [7:0] IND2_HIGH_OFS  = 8'h84;
    localparam logic [7:0] FLAGS_OFS      = 8'h86;
    localparam logic [7:0] BANK_SEL_OFS   = 8'h87;
    localparam logic [7:0] CAPT_MODE_OFS  = 8'ha0;
    localparam logic [7:0] CAPT_CLOW_OFS  = 8'ha1;
    localparam logic [7:0] CAPT_CHIGH_OFS = 8'ha2;
    localparam logic [7:0] EVT_LOW_OFS    = 8'ha3;
    localparam logic [7:0] EVT_HIGH_OFS   = 8'ha4;
    localparam logic [7:0] CAPT_CTRL_OFS  = 8'ha5;
    localparam logic [7:0] RCONV_MODE_OFS = 8'ha6;
    localparam logic [7:0] PORT0_DIR_OFS  = 8'hb8;
    localparam logic [7:0] EDGE_SEL_OFS   = 8'hbf;
    localparam logic [7:0] WAKE_EN_OFS    = 8'hc0;
    localparam logic [7:0] PORT1_DIR_OFS  = 8'hc1;
    localparam logic [7:0] PORT2_DIR_OFS  = 8'hc2;
    localparam logic [7:0] PORT3_DIR_OFS  = 8'hc3;
    localparam logic [7:0] PORT5_DIR_OFS  = 8'hc5;
    localparam logic [7:0] IRQ_FLAGS_OFS  = 8'hc8;
    localparam logic [7:0] IRQ_MASK_OFS   = 8'hc9;
    localparam logic [7:0] OSC_MODE_OFS   = 8'hca;
    localparam logic [7:0] DISP_MODE_OFS  = 8'hcb;
    localparam logic [7:0] WDOG_CLR_OFS   = 8'hcc;
    localparam logic [7:0] PWM_RELOAD_OFS = 8'hcd;
    localparam logic [7:0] PC_LOW_OFS     = 8'hce;
    localparam logic [7:0] PC_HIGH_OFS    = 8'hcf;
    localparam logic [7:0] PORT0_DATA_OFS = 8'hd0;
    localparam logic [7:0] PORT1_DATA_OFS = 8'hd1;
    localparam logic [7:0] PORT2_DATA_OFS = 8'hd2;
    localparam logic [7:0] PORT3_DATA_OFS = 8'hd3;
    localparam logic [7:0] PORT5_DATA_OFS = 8'hd5;
    localparam logic [7:0] BT_MODE_OFS    = 8'hd8;
    localparam logic [7:0] BT_COUNT_OFS   = 8'hd9;
    localparam logic [7:0] PWM_MODE_OFS   = 8'hda;
    localparam logic [7:0] PWM_COUNT_OFS  = 8'hdb;
    localparam logic [7:0] STACK_PTR_OFS  = 8'hdf;
    localparam logic [7:0] PORT0_PU_OFS   = 8'he0;
    localparam logic [7:0] PORT1_PU_OFS   = 8'he1;
    localparam logic [7:0] PORT2_PU_OFS   = 8'he2;
    localparam logic [7:0] PORT3_PU_OFS   = 8'he3;
    localparam logic [7:0] PORT5_PU_OFS   = 8'he5;
    localparam logic [7:0] IND1_PORT_OFS  = 8'he6;
    localparam logic [7:0] IND2_PORT_OFS  = 8'he7;
    localparam logic [7:0] PWM_DUTY_OFS   = 8'he8;
    localparam logic [7:0] STACK_BASE_OFS = 8'hf0;

    // ****************************************
    // field layout and fixed values
    // ****************************************
    localparam int unsigned BANK_SELECT_BIT   = 0;
    localparam int unsigned LOW_VOLTAGE_LSB   = 4;
    localparam logic [7:0]  FLAGS_HW_MASK     = 8'h30;
    localparam logic [7:0]  RCONV_FIXED_MASK  = 8'h30;
    localparam logic [7:0]  RCONV_FIXED_VALUE = 8'h10;
    localparam logic [7:0]  IRQ_FIELD_MASK    = 8'h73;
    localparam logic [7:0]  STACK_HIGH_MASK   = 8'h0f;

    // ****************************************
    // carrier types
    // ****************************************
    typedef enum logic [1:0] {
        DMSR_OP_READ  = 2'b00,
        DMSR_OP_WRITE = 2'b01,
        DMSR_OP_BSET  = 2'b11,
        DMSR_OP_BCLR  = 2'b10
    } dmsr_op_t;

    typedef enum logic [1:0] {
        DMSR_TGT_NONE = 2'b00,
        DMSR_TGT_GEN  = 2'b01,
        DMSR_TGT_SYS  = 2'b11,
        DMSR_TGT_LCD  = 2'b10
    } dmsr_tgt_t;

    typedef struct packed {
        logic       valid;
        dmsr_op_t   op;
        logic       bank0_type;
        logic [7:0] addr;
        logic [2:0] bit_idx;
        logic [7:0] wdata;
    } dmsr_req_t;

    typedef struct packed {
        logic       valid;
        logic       refused;
        logic [7:0] rdata;
    } dmsr_resp_t;

    typedef struct packed {
        logic [11:0] pc;
        logic        bank_select;
        logic [7:0]  pwm_reload;
        logic        wdog_clear;
        logic [7:0]  wdog_value;
        logic        irq_pending;
        logic [7:0]  capture_mode;
        logic [7:0]  osc_mode;
        logic [7:0]  display_mode;
    } dmsr_ctl_t;

    // writable bits of each system register; zero marks an unassigned address
    function automatic logic [7:0] dmsr_wmask(input logic [7:0] a);
        logic [7:0] m;
        m = 8'h00;
        case (a)
            IND1_LOW_OFS, IND1_HIGH_OFS, LOOKUP_BUF_OFS, IND2_LOW_OFS, IND2_HIGH_OFS: m = 8'hff;
            FLAGS_OFS:      m = 8'hc7;
            BANK_SEL_OFS:   m = 8'h01;
            CAPT_MODE_OFS:  m = 8'hf8;
            CAPT_CLOW_OFS, CAPT_CHIGH_OFS, EVT_LOW_OFS: m = 8'hff;
            EVT_HIGH_OFS:   m = 8'h03;
            CAPT_CTRL_OFS:  m = 8'h8f;
            RCONV_MODE_OFS: m = 8'h8f;
            PORT0_DIR_OFS, PORT0_PU_OFS: m = 8'h17;
            EDGE_SEL_OFS:   m = 8'h18;
            WAKE_EN_OFS, PORT1_DIR_OFS, PORT1_DATA_OFS, PORT1_PU_OFS: m = 8'h7f;
            PORT2_DIR_OFS, PORT3_DIR_OFS, PORT2_DATA_OFS, PORT3_DATA_OFS: m = 8'hff;
            PORT2_PU_OFS, PORT3_PU_OFS: m = 8'hff;
            PORT5_DIR_OFS, PORT5_DATA_OFS, PORT5_PU_OFS: m = 8'h10;
            IRQ_FLAGS_OFS, IRQ_MASK_OFS: m = IRQ_FIELD_MASK;
            OSC_MODE_OFS:   m = 8'h1e;
            DISP_MODE_OFS, WDOG_CLR_OFS, PWM_RELOAD_OFS, PC_LOW_OFS: m = 8'hff;
            PC_HIGH_OFS:    m = 8'h0f;
            PORT0_DATA_OFS: m = 8'h1f;
            BT_MODE_OFS:    m = 8'hf1;
            BT_COUNT_OFS, PWM_COUNT_OFS, PWM_DUTY_OFS: m = 8'hff;
            PWM_MODE_OFS:   m = 8'hfd;
            STACK_PTR_OFS:  m = 8'h87;
            default: begin
                if (a >= STACK_BASE_OFS) begin
                    m = a[0] ? STACK_HIGH_MASK : 8'hff;
                end
            end
        endcase
        return m;
    endfunction : dmsr_wmask

    function automatic logic dmsr_write_only(input logic [7:0] a);
        logic w;
        w = 1'b0;
        case (a)
            WAKE_EN_OFS, WDOG_CLR_OFS, PWM_RELOAD_OFS: w = 1'b1;
            PORT0_PU_OFS, PORT1_PU_OFS, PORT2_PU_OFS, PORT3_PU_OFS, PORT5_PU_OFS: w = 1'b1;
            default: w = 1'b0;
        endcase
        return w;
    endfunction : dmsr_write_only

endpackage : dmsr_pkg

// ===== verilog/dmsr_regs.sv
// data memory map, system register file and indirect access ports of the core
//
// Operation
// - bank 0 addresses 000h-07Fh are 128 bytes of general read/write RAM.
// - bank 0 addresses 080h-0FFh reach the system register space, not RAM.
// - bank 15 addresses 00h-1Fh hold 32 bytes of display segment RAM.
// - bank-0-type accesses always hit bank 0 whatever the bank selection says.
// - bank selection register at 087h, bit 0 selects the bank for ordinary accesses.
// - first indirect port acts on RAM addressed by pointer bytes 081h:080h.
// - second indirect port acts on RAM addressed by pointer bytes 084h:083h.
// - byte 082h is a working register and the table look-up upper-byte buffer.
// - 12-bit program counter, low byte at 0CEh, bits 11:8 low nibble at 0CFh.
// - watchdog clear at 0CCh is write-only; a write restarts the watchdog count.
// - reload buffer at 0CDh is write-only and supplies the PWM timer reload value.
// - request flags 0C8h and enables 0C9h use bits 6,5,4,1,0.
// - flags 086h: reset cause 7:6, low voltage 5:4, carry 2, decimal carry 1, zero 0.
// - eight return-address slots at 0F0h-0FFh, low byte then high nibble.
// - write-only wake-up enables at 0C0h, bits 6:0, one per port 1 pin.
// - direction bits sit at the same position as their pin in the data register.
// - edge selection at 0BFh, bits 4:3 choose the external input zero edge.
// - capture timer mode 0A0h: enable bit 7, rate 6:4, clock source bit 3.
// - 10-bit event counter, low byte 0A3h, upper two bits at 0A4h bits 1:0.
// - oscillator mode 0CAh: mode 4:3, clock mode bit 2, fast oscillator stop bit 1.
// - display mode 0CBh: pump clock 7:6, pump enable 5, segments 4:2, bias 1, enable 0.
// - converter mode 0A6h keeps bit 5 at zero and bit 4 at one.
// - single-bit set and clear work only on readable and writable registers.
`timescale 1ns/1ns

module dmsr_regs (
    input  wire logic                clk,
    input  wire logic                rst_b,
    input  wire dmsr_pkg::dmsr_req_t req,
    input  wire logic [1:0]          low_voltage_pins,
    input  wire logic [7:0]          irq_events,
    output      dmsr_pkg::dmsr_resp_t resp,
    output      dmsr_pkg::dmsr_ctl_t  ctl
);
    import dmsr_pkg::*;

    // ****************************************
    // state
    // ****************************************
    typedef struct packed {
        logic [127:0][7:0] sysreg;
        dmsr_resp_t        resp;
        dmsr_ctl_t         ctl;
        logic [1:0]        lv_s1;
        logic [1:0]        lv_s2;
        logic [1:0]        lv_s3;
        logic [1:0]        lv_stable;
    } dmsr_state_t;

    typedef struct packed {
        dmsr_tgt_t  kind;
        logic [7:0] off;
    } dmsr_loc_t;

    dmsr_state_t st;
    dmsr_state_t next_st;

    logic [7:0] gen_ram [DMSR_GEN_DEPTH];
    logic [7:0] lcd_ram [DMSR_LCD_DEPTH];

    logic       gen_we;
    logic [6:0] gen_wa;
    logic [4:0] lcd_wa;
    logic       lcd_we;
    logic [7:0] mem_wd;

    // ****************************************
    // address resolution
    // ****************************************
    // indirect targets into the system space resolve to nothing: no recursion through the ports
    function automatic dmsr_loc_t resolve(input logic [3:0] bank, input logic [7:0] off, input logic allow_sys);
        dmsr_loc_t l;
        l.kind = DMSR_TGT_NONE;
        l.off  = off;
        if (bank == DMSR_BANK_ZERO) begin
            if (off <= DMSR_GEN_LAST) begin
                l.kind = DMSR_TGT_GEN;
            end else if (allow_sys) begin
                l.kind = DMSR_TGT_SYS;
            end
        end else if (bank == DMSR_BANK_LCD && off <= DMSR_LCD_LAST) begin
            l.kind = DMSR_TGT_LCD;
        end
        return l;
    endfunction : resolve

    function automatic logic [7:0] sys_read(input dmsr_state_t s, input logic [7:0] a);
        logic [7:0] v;
        v = s.sysreg[a[6:0]] & dmsr_wmask(a);
        if (a == FLAGS_OFS) begin
            v = v | (s.sysreg[a[6:0]] & FLAGS_HW_MASK);
        end
        if (a == RCONV_MODE_OFS) begin
            v = v | RCONV_FIXED_VALUE;
        end
        if (dmsr_write_only(a)) begin
            v = 8'h00;
        end
        return v;
    endfunction : sys_read

    // ****************************************
    // next state
    // ****************************************
    always_comb begin
        dmsr_loc_t  loc;
        logic [3:0] bank;
        logic [7:0] cur;
        logic [7:0] newv;
        logic [7:0] wm;
        logic       is_bitop;
        logic       refuse;
        logic [7:0] ptr_lo;
        logic [7:0] ptr_hi;
        loc      = '{kind: DMSR_TGT_NONE, off: 8'h00};
        bank     = 4'h0;
        cur      = 8'h00;
        newv     = 8'h00;
        wm       = 8'h00;
        is_bitop = 1'b0;
        refuse   = 1'b0;
        ptr_lo   = 8'h00;
        ptr_hi   = 8'h00;
        gen_we   = 1'b0;
        gen_wa   = 7'h00;
        lcd_we   = 1'b0;
        lcd_wa   = 5'h00;
        mem_wd   = 8'h00;

        next_st                = st;
        next_st.resp.valid     = 1'b0;
        next_st.resp.refused   = 1'b0;
        next_st.ctl.wdog_clear = 1'b0;

        // low-voltage indications come from the analogue side, so they are synchronised
        next_st.lv_s1 = low_voltage_pins;
        next_st.lv_s2 = st.lv_s1;
        next_st.lv_s3 = st.lv_s2;
        if (st.lv_s2 == st.lv_s3) begin
            next_st.lv_stable = st.lv_s3;
        end

        if (req.valid) begin
            if (req.bank0_type) begin
                bank = DMSR_BANK_ZERO;
            end else begin
                bank = {3'b000, st.sysreg[BANK_SEL_OFS[6:0]][BANK_SELECT_BIT]};
            end
            loc = resolve(bank, req.addr, 1'b1);
            if (loc.kind == DMSR_TGT_SYS && req.addr == IND1_PORT_OFS) begin
                ptr_lo = st.sysreg[IND1_LOW_OFS[6:0]];
                ptr_hi = st.sysreg[IND1_HIGH_OFS[6:0]];
                loc    = resolve(ptr_hi[3:0], ptr_lo, 1'b0);
            end else if (loc.kind == DMSR_TGT_SYS && req.addr == IND2_PORT_OFS) begin
                ptr_lo = st.sysreg[IND2_LOW_OFS[6:0]];
                ptr_hi = st.sysreg[IND2_HIGH_OFS[6:0]];
                loc    = resolve(ptr_hi[3:0], ptr_lo, 1'b0);
            end

            case (loc.kind)
                DMSR_TGT_GEN: begin
                    cur = gen_ram[loc.off[6:0]];
                    wm  = 8'hff;
                end
                DMSR_TGT_LCD: begin
                    cur = lcd_ram[loc.off[4:0]];
                    wm  = 8'hff;
                end
                DMSR_TGT_SYS: begin
                    cur = sys_read(st, loc.off);
                    wm  = dmsr_wmask(loc.off);
                end
                default: begin
                    cur = 8'h00;
                    wm  = 8'h00;
                end
            endcase

            is_bitop = (req.op == DMSR_OP_BSET) || (req.op == DMSR_OP_BCLR);
            refuse   = is_bitop && loc.kind == DMSR_TGT_SYS && dmsr_write_only(loc.off);
            case (req.op)
                DMSR_OP_WRITE: newv = req.wdata;
                DMSR_OP_BSET:  newv = cur | (8'h01 << req.bit_idx);
                DMSR_OP_BCLR:  newv = cur & ~(8'h01 << req.bit_idx);
                default:       newv = cur;
            endcase

            next_st.resp.valid   = 1'b1;
            next_st.resp.refused = refuse;
            next_st.resp.rdata   = cur;

            if (req.op != DMSR_OP_READ && !refuse) begin
                case (loc.kind)
                    DMSR_TGT_GEN: begin
                        gen_we = 1'b1;
                        gen_wa = loc.off[6:0];
                        mem_wd = newv;
                    end
                    DMSR_TGT_LCD: begin
                        lcd_we = 1'b1;
                        lcd_wa = loc.off[4:0];
                        mem_wd = newv;
                    end
                    DMSR_TGT_SYS: begin
                        // only the mapped bits store; fixed and reserved bits keep their value
                        next_st.sysreg[loc.off[6:0]] = (st.sysreg[loc.off[6:0]] & ~wm) | (newv & wm);
                        if (loc.off == WDOG_CLR_OFS) begin
                            next_st.ctl.wdog_clear = 1'b1;
                            next_st.ctl.wdog_value = newv;
                        end
                    end
                    default: begin
                    end
                endcase
            end
        end

        // hardware set beats a software clear in the same cycle
        next_st.sysreg[IRQ_FLAGS_OFS[6:0]] = next_st.sysreg[IRQ_FLAGS_OFS[6:0]] | (irq_events & IRQ_FIELD_MASK);
        next_st.sysreg[FLAGS_OFS[6:0]][LOW_VOLTAGE_LSB +: 2] = next_st.lv_stable;
        next_st.sysreg[RCONV_MODE_OFS[6:0]] = (next_st.sysreg[RCONV_MODE_OFS[6:0]] & ~RCONV_FIXED_MASK)
                                              | RCONV_FIXED_VALUE;

        next_st.ctl.pc = {next_st.sysreg[PC_HIGH_OFS[6:0]][3:0], next_st.sysreg[PC_LOW_OFS[6:0]]};
        next_st.ctl.bank_select  = next_st.sysreg[BANK_SEL_OFS[6:0]][BANK_SELECT_BIT];
        next_st.ctl.pwm_reload   = next_st.sysreg[PWM_RELOAD_OFS[6:0]];
        next_st.ctl.irq_pending  = |(next_st.sysreg[IRQ_FLAGS_OFS[6:0]] & next_st.sysreg[IRQ_MASK_OFS[6:0]]
                                     & IRQ_FIELD_MASK);
        next_st.ctl.capture_mode = next_st.sysreg[CAPT_MODE_OFS[6:0]] & dmsr_wmask(CAPT_MODE_OFS);
        next_st.ctl.osc_mode     = next_st.sysreg[OSC_MODE_OFS[6:0]] & dmsr_wmask(OSC_MODE_OFS);
        next_st.ctl.display_mode = next_st.sysreg[DISP_MODE_OFS[6:0]];
    end

    // ****************************************
    // registers
    // ****************************************
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    // RAM has no reset: contents are undefined until software writes them
    always_ff @(posedge clk) begin
        if (gen_we) begin
            gen_ram[gen_wa] <= mem_wd;
        end
        if (lcd_we) begin
            lcd_ram[lcd_wa] <= mem_wd;
        end
    end

    assign resp = st.resp;
    assign ctl  = st.ctl;

endmodule : dmsr_regs

// ===== testbench/dmsr_regs_assertions.sv
// checker: port-level relations of the data memory register bank
`timescale 1ns/1ns

module dmsr_regs_assertions (
    input wire logic                 clk,
    input wire logic                 rst_b,
    input wire dmsr_pkg::dmsr_req_t  req,
    input wire logic [1:0]           low_voltage_pins,
    input wire logic [7:0]           irq_events,
    input wire dmsr_pkg::dmsr_resp_t resp,
    input wire dmsr_pkg::dmsr_ctl_t  ctl
);
    import dmsr_pkg::*;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);

    // ****************************************
    // helpers
    // ****************************************
    logic hit;
    logic wr_op;
    logic wdog_wr;
    // an ordinary access with bank select 1 reaches no system register
    assign hit     = req.valid && (req.bank0_type || !ctl.bank_select);
    assign wr_op   = hit && req.op == DMSR_OP_WRITE;
    assign wdog_wr = wr_op && req.addr == 8'hcc;

    // ****************************************
    // assertions
    // ****************************************
    AST_ANSWER: assert property (resp.valid == $past(req.valid))
        else $error("answer not one cycle after request");
    AST_WO_BITOP: assert property (hit && req.op[1] && req.addr inside {8'hc0, 8'hcc, 8'hcd} |=> resp.refused)
        else $error("bit op on write-only register not refused");
    AST_RAM_BITOP: assert property (req.valid && req.op[1] && req.addr < 8'h80 |=> !resp.refused)
        else $error("bit op on RAM refused");
    AST_WO_READ: assert property (hit && req.op == DMSR_OP_READ && req.addr inside {8'hc0, 8'hcc, 8'hcd}
        |=> resp.rdata == 8'h00)
        else $error("write-only register read not zero");
    AST_WDOG_WRITE: assert property (wdog_wr |=> ctl.wdog_clear && ctl.wdog_value == $past(req.wdata))
        else $error("watchdog clear write lost");
    AST_WDOG_CAUSE: assert property (ctl.wdog_clear |-> $past(wdog_wr))
        else $error("watchdog clear without write");
    AST_RELOAD: assert property (wr_op && req.addr == 8'hcd |=> ctl.pwm_reload == $past(req.wdata))
        else $error("reload buffer not loaded");
    AST_PC_LOW: assert property (wr_op && req.addr == 8'hce |=> ctl.pc[7:0] == $past(req.wdata))
        else $error("program counter low byte wrong");
    AST_PC_HIGH: assert property (wr_op && req.addr == 8'hcf
        |=> {4'h0, ctl.pc[11:8]} == ($past(req.wdata) & 8'h0f))
        else $error("program counter high nibble wrong");
    AST_BANK: assert property (wr_op && req.addr == 8'h87
        |=> {7'h0, ctl.bank_select} == ($past(req.wdata) & 8'h01))
        else $error("bank select not taken from bit 0");
    AST_CAPT: assert property (wr_op && req.addr == 8'ha0 |=> ctl.capture_mode == ($past(req.wdata) & 8'hf8))
        else $error("capture mode fields wrong");
    AST_OSC: assert property (wr_op && req.addr == 8'hca |=> ctl.osc_mode == ($past(req.wdata) & 8'h1e))
        else $error("oscillator mode fields wrong");
    AST_DISP: assert property (wr_op && req.addr == 8'hcb |=> ctl.display_mode == $past(req.wdata))
        else $error("display mode fields wrong");

    COV_WDOG: cover property (wdog_wr);
    COV_REFUSED: cover property (resp.valid && resp.refused);
    COV_IRQ: cover property (ctl.irq_pending);
endmodule : dmsr_regs_assertions

// ===== testbench/dmsr_core_model.sv
// core model: issues data memory requests, one per cycle while called back to back
`timescale 1ns/1ns

module dmsr_core_model (
    input  wire logic                 clk,
    output      dmsr_pkg::dmsr_req_t  req,
    input  wire dmsr_pkg::dmsr_resp_t resp
);
    import dmsr_pkg::*;

    initial begin
        req = '0;
    end

    // caller sits just after a falling edge; valid stays up so calls run back to back
    task automatic xfer(input dmsr_op_t op, input logic b0, input logic [7:0] a, input logic [2:0] b,
                        input logic [7:0] d, output dmsr_resp_t rs);
        req.valid      = 1'b1;
        req.op         = op;
        req.bank0_type = b0;
        req.addr       = a;
        req.bit_idx    = b;
        req.wdata      = (a == RCONV_MODE_OFS) ? ((d & 8'hcf) | RCONV_FIXED_VALUE) : d;
        @(posedge clk);
        @(negedge clk);
        rs = resp;
    endtask : xfer

    task automatic idle();
        req.valid = 1'b0;
        // released lines must not keep the last value
        req.addr  = ~req.addr;
        req.wdata = ~req.wdata;
        @(negedge clk);
    endtask : idle
endmodule : dmsr_core_model

// ===== testbench/dmsr_regs_test.sv
// testbench: reference model of the data memory map compared with the register bank
`timescale 1ns/1ns

module dmsr_regs_test;
    import dmsr_pkg::*;

    logic        clk;
    logic        rst_b;
    logic [1:0]  low_voltage_pins;
    logic [7:0]  irq_events;
    dmsr_req_t   req;
    dmsr_resp_t  resp;
    dmsr_ctl_t   ctl;
    dmsr_resp_t  rs;
    int          error_cnt;
    int          cmp_count;
    int          gen_mem [128];
    logic [7:0]  q_addr [$];
    logic [7:0]  a;
    int          v;
    // address and readable mask after writing all ones
    logic [15:0] tbl [24] = '{16'h82ff, 16'h86c7, 16'h8701, 16'ha0f8, 16'ha3ff, 16'ha403, 16'ha69f, 16'hb817,
                              16'hbf18, 16'hc000, 16'hc17f, 16'hc2ff, 16'hc873, 16'hc973, 16'hca1e, 16'hcbff,
                              16'hcc00, 16'hcd00, 16'hceff, 16'hcf0f, 16'hf0ff, 16'hf10f, 16'hff0f, 16'h8500};

    dmsr_regs i_dmsr_regs (.clk(clk), .rst_b(rst_b), .req(req), .low_voltage_pins(low_voltage_pins),
                           .irq_events(irq_events), .resp(resp), .ctl(ctl));
    dmsr_core_model i_dmsr_core_model (.clk(clk), .req(req), .resp(resp));

    always #10 clk = ~clk;

    // ****************************************
    // tasks
    // ****************************************
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic end_sim();
        $display("mismatches %0d comparisons %0d", error_cnt, cmp_count);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : end_sim

    task automatic wr(input logic [7:0] ad, input logic [7:0] d);
        i_dmsr_core_model.xfer(DMSR_OP_WRITE, 1'b1, ad, 3'h0, d, rs);
    endtask : wr

    task automatic rd(input logic [7:0] ad);
        i_dmsr_core_model.xfer(DMSR_OP_READ, 1'b1, ad, 3'h0, 8'h00, rs);
    endtask : rd

    // ****************************************
    // sequence
    // ****************************************
    initial begin
        clk = 1'b0;
        rst_b = 1'b0;
        low_voltage_pins = 2'b00;
        irq_events = 8'h00;
        error_cnt = 0;
        cmp_count = 0;
        v = $urandom(32'hc98d);
        repeat (3) @(negedge clk);
        rst_b = 1'b1;
        @(negedge clk);
        rd(8'ha6);
        check(rs.rdata, 8'h10);
        rd(8'h87);
        check(rs.rdata, 8'h00);
        foreach (tbl[k]) begin
            wr(tbl[k][15:8], 8'hff);
            rd(tbl[k][15:8]);
            check(rs.rdata, tbl[k][7:0]);
        end
        check({7'h0, ctl.irq_pending}, 8'h01);
        check(ctl.pc[7:0], 8'hff);
        check({4'h0, ctl.pc[11:8]}, 8'h0f);
        check(ctl.pwm_reload, 8'hff);
        check(ctl.wdog_value, 8'hff);
        check(ctl.capture_mode, 8'hf8);
        check(ctl.osc_mode, 8'h1e);
        check(ctl.display_mode, 8'hff);
        check({7'h0, ctl.bank_select}, 8'h01);
        // bank select is 1 here: only the forced form reaches bank 0
        i_dmsr_core_model.xfer(DMSR_OP_WRITE, 1'b0, 8'h10, 3'h0, 8'h5a, rs);
        wr(8'h10, 8'ha5);
        gen_mem[16] = 8'ha5;
        i_dmsr_core_model.xfer(DMSR_OP_READ, 1'b0, 8'h10, 3'h0, 8'h00, rs);
        check(rs.rdata, 8'h00);
        q_addr.push_back(8'h10);
        foreach (tbl[k]) begin
            wr(tbl[k][15:8], 8'h00);
            rd(tbl[k][15:8]);
            check(rs.rdata, (tbl[k][15:8] == 8'ha6) ? 8'h10 : 8'h00);
        end
        check({7'h0, ctl.irq_pending}, 8'h00);
        for (int i = 0; i < 24; i++) begin
            a = (i == 0) ? 8'h00 : (i == 1) ? 8'h7f : 8'($urandom_range(127));
            v = $urandom_range(255);
            wr(a, 8'(v));
            gen_mem[a] = v;
            q_addr.push_back(a);
        end
        wr(8'h81, 8'h00);
        wr(8'h80, 8'h20);
        wr(8'he6, 8'h3c);
        gen_mem[32] = 8'h3c;
        q_addr.push_back(8'h20);
        wr(8'h84, 8'h0f);
        wr(8'h83, 8'h1f);
        wr(8'he7, 8'hc3);
        wr(8'h81, 8'h0f);
        wr(8'h80, 8'h1f);
        rd(8'he6);
        check(rs.rdata, 8'hc3);
        wr(8'h80, 8'h20);
        rd(8'he6);
        check(rs.rdata, 8'h00);
        i_dmsr_core_model.xfer(DMSR_OP_BSET, 1'b1, 8'h7f, 3'h3, 8'h00, rs);
        check({7'h0, rs.refused}, 8'h00);
        gen_mem[127] = gen_mem[127] | 8;
        while (q_addr.size() > 0) begin
            a = q_addr.pop_front();
            rd(a);
            check(rs.rdata, gen_mem[a][7:0]);
        end
        rd(8'h7f);
        check(rs.rdata, gen_mem[127][7:0]);
        i_dmsr_core_model.xfer(DMSR_OP_BSET, 1'b1, 8'hcc, 3'h0, 8'h00, rs);
        check({7'h0, rs.refused}, 8'h01);
        wr(8'hc9, 8'h40);
        i_dmsr_core_model.idle();
        irq_events = 8'h44;
        @(negedge clk);
        irq_events = 8'h00;
        repeat (2) @(negedge clk);
        check({7'h0, ctl.irq_pending}, 8'h01);
        rd(8'hc8);
        check(rs.rdata, 8'h40);
        i_dmsr_core_model.xfer(DMSR_OP_BCLR, 1'b1, 8'hc8, 3'h6, 8'h00, rs);
        rd(8'hc8);
        check(rs.rdata, 8'h00);
        low_voltage_pins = 2'b10;
        i_dmsr_core_model.idle();
        repeat (6) @(negedge clk);
        rd(8'h86);
        check(rs.rdata, 8'h20);
        i_dmsr_core_model.idle();
        end_sim();
    end

    // the sequence needs well under 500 cycles
    initial begin
        #100000;
        error_cnt++;
        end_sim();
    end
endmodule : dmsr_regs_test

bind dmsr_regs dmsr_regs_assertions i_dmsr_regs_assertions (.clk(clk), .rst_b(rst_b), .req(req),
    .low_voltage_pins(low_voltage_pins), .irq_events(irq_events), .resp(resp), .ctl(ctl));
